// ===== design/pmm_pkg.sv
// Constants and types for the program memory block
package pmm_pkg;

    // --------------------------------------------------------------
    // Widths and storage shape
    // --------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam int WORD_W = 16;
    localparam int INSTR_W = 24;
    localparam int BYTE_W = 8;
    localparam int IMPL_INSTR = 1024;
    localparam int IDX_W = 10;
    localparam int WB_INSTR = 8;
    localparam int WB_W = 3;
    localparam int EB_INSTR = 64;
    localparam int EB_W = 6;
    localparam int WBN_W = IDX_W - WB_W;
    localparam int WB_PER_EB = EB_INSTR / WB_INSTR;
    localparam int CNT_W = 8;
    localparam int CFG_BIT = 23;

    // --------------------------------------------------------------
    // Address map
    // --------------------------------------------------------------
    localparam logic [ADDR_W-1:0] RESET_VEC = 24'h000000;
    localparam logic [ADDR_W-1:0] VEC_TOP = 24'h0001ff;
    localparam logic [ADDR_W-1:0] IVT_BASE = 24'h000006;
    localparam logic [ADDR_W-1:0] IVT_TOP = 24'h0000ff;
    localparam logic [ADDR_W-1:0] AIVT_BASE = 24'h000106;
    localparam logic [ADDR_W-1:0] USER_TOP = 24'h7fffff;
    localparam logic [ADDR_W-1:0] IMPL_TOP = 24'h0007ff;
    localparam logic [ADDR_W-1:0] DEVID_ADDR = 24'hff0000;
    localparam logic [ADDR_W-1:0] DEVREV_ADDR = 24'hff0002;
    localparam logic [ADDR_W-1:0] PC_STEP = 24'h000002;
    localparam logic [6:0] NUM_VECTORS = 7'h76;
    localparam logic [IDX_W-1:0] CFG1_IDX = 10'h3fe;
    localparam logic [IDX_W-1:0] CFG2_IDX = 10'h3ff;

    // --------------------------------------------------------------
    // Values
    // --------------------------------------------------------------
    localparam logic [INSTR_W-1:0] ERASED_VAL = 24'hffffff;
    localparam logic [BYTE_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [WORD_W-1:0] DEV_ID_VAL = 16'h5a3c;  // Arbitrary value
    localparam logic [WORD_W-1:0] DEV_REV_VAL = 16'h0001; // Arbitrary value
    localparam logic [BYTE_W-1:0] KEY1 = 8'h55;
    localparam logic [BYTE_W-1:0] KEY2 = 8'haa;

    // --------------------------------------------------------------
    // Control register bits
    // --------------------------------------------------------------
    localparam int CTL_WR = 0;
    localparam int CTL_WREN = 1;
    localparam int CTL_ERASE = 2;
    localparam int CTL_WRERR = 3;

    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int ERASE_TIME_NS = 3000;
    localparam int WRITE_TIME_NS = 1000;
    localparam int ERASE_CYC = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYC = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG} pmm_state_t;
    typedef enum logic [1:0] {KEY_LOCKED, KEY_HALF, KEY_OPEN} pmm_key_t;

endpackage : pmm_pkg

// ===== design/pmm_program_memory.sv
// Program memory array with fetch, table access, vectors and self-timed flash
`timescale 1ns/10ps
// Overview of operation
// - 24-bit locations, two word addresses each
// - Even word lower, odd word upper
// - Even aligned, counter steps by two
// - Upper word padded with zero byte
// - Odd upper byte reads zero, unwritable
// - Table access by word or byte
// - Program counter is 24 bits wide
// - User space ends at 7FFFFFh
// - Reset vector at 00h, vectors reserved
// - Primary vector table, 118 vectors
// - Alternate vector table for emulation
// - Config words in last two locations
// - Device IDs at FF0000h, FF0002h
// - Fetch only from on-chip memory
// - No protected boot region
// - Erase block before writing block
// - Self-timed write stalls the CPU
// - One control, one key register
// - Writes refused in configuration space
module pmm_program_memory
    import pmm_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic fetch_step_in,
    input wire logic jump_in,
    input wire logic [ADDR_W-1:0] jump_addr_in,
    output logic [ADDR_W-1:0] pc_out,
    output logic [INSTR_W-1:0] instr_out,
    input wire logic tbl_req_in,
    input wire logic table_read_op_in,
    input wire logic table_write_op_in,
    input wire logic [7:0] table_page_select_in,
    input wire logic [WORD_W-1:0] tbl_offset_in,
    input wire logic tbl_byte_in,
    input wire logic tbl_hi_byte_in,
    input wire logic [WORD_W-1:0] tbl_wdata_in,
    output logic [WORD_W-1:0] tbl_rdata_out,
    output logic tbl_ack_out,
    output logic tbl_refused_out,
    input wire logic vec_req_in,
    input wire logic vec_alt_in,
    input wire logic [6:0] vec_num_in,
    output logic [INSTR_W-1:0] vec_addr_out,
    output logic vec_valid_out,
    input wire logic nvm_ctrl_wr_in,
    input wire logic [7:0] nvm_ctrl_in,
    input wire logic nvm_key_wr_in,
    input wire logic [7:0] nvm_key_in,
    output logic [7:0] nvm_ctrl_out,
    output logic stall_out,
    output logic [WORD_W-1:0] cfg_word1_out,
    output logic [WORD_W-1:0] cfg_word2_out
);

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    function automatic logic is_impl(input logic [ADDR_W-1:0] a);
        return a <= IMPL_TOP;
    endfunction : is_impl

    function automatic logic [IDX_W-1:0] idx_of(input logic [ADDR_W-1:0] a);
        return a[IDX_W:1];
    endfunction : idx_of

    function automatic logic [WORD_W-1:0] sel_word(input logic [INSTR_W-1:0] w, input logic upper);
        return upper ? {ZERO_BYTE, w[INSTR_W-1:WORD_W]} : w[WORD_W-1:0];
    endfunction : sel_word

    localparam int A_ERASE_MIN = ERASE_CYC - 7;
    localparam int A_ERASE_MAX = ERASE_CYC - 7;

    logic [INSTR_W-1:0] mem [IMPL_INSTR];
    logic [INSTR_W-1:0] latch_q [WB_INSTR];
    logic [WBN_W-1:0] latch_wb_q;
    logic [IMPL_INSTR/WB_INSTR-1:0] erased_q;
    pmm_state_t state_q;
    pmm_key_t key_q;
    logic [CNT_W-1:0] cnt_q;
    logic [ADDR_W-1:0] pc_q;
    logic [INSTR_W-1:0] instr_q;
    logic [WORD_W-1:0] rdata_q;
    logic ack_q;
    logic refused_q;
    logic [INSTR_W-1:0] vec_q;
    logic vec_valid_q;
    logic [7:0] ctrl_q;
    logic stall_q;
    logic [WORD_W-1:0] cfg1_q;
    logic [WORD_W-1:0] cfg2_q;

    logic idle;
    logic finish;
    logic start_req;
    logic go_erase;
    logic go_prog;
    logic prog_err;
    logic [ADDR_W-1:0] tbl_addr;
    logic tbl_cfg;
    logic tbl_take;
    logic wr_ok;
    logic wr_refused;
    logic [WORD_W-1:0] rd_word;
    logic [ADDR_W-1:0] vec_loc;
    logic [IDX_W-1:0] tbl_idx;

    // --------------------------------------------------------------
    // Decode
    // --------------------------------------------------------------
    always_comb
    begin
        idle = state_q == ST_IDLE;
        finish = (state_q == ST_ERASE && cnt_q == CNT_W'(ERASE_CYC - 1)) ||
                 (state_q == ST_PROG && cnt_q == CNT_W'(WRITE_CYC - 1));
        start_req = nvm_ctrl_wr_in && nvm_ctrl_in[CTL_WR] && nvm_ctrl_in[CTL_WREN] &&
                    key_q == KEY_OPEN && idle;
        go_erase = start_req && nvm_ctrl_in[CTL_ERASE];
        go_prog = start_req && !nvm_ctrl_in[CTL_ERASE] && erased_q[latch_wb_q];
        prog_err = start_req && !nvm_ctrl_in[CTL_ERASE] && !erased_q[latch_wb_q];
        tbl_addr = {table_page_select_in, tbl_offset_in};
        tbl_idx = idx_of(tbl_addr);
        tbl_cfg = tbl_addr[CFG_BIT];
        tbl_take = tbl_req_in && idle && (table_read_op_in || table_write_op_in);
        // No boot region exists, so every implemented user word is writable
        wr_ok = tbl_take && !table_read_op_in && !tbl_cfg && is_impl(tbl_addr);
        wr_refused = tbl_take && !table_read_op_in && tbl_cfg;
        if (tbl_cfg)
        begin
            if (tbl_addr == DEVID_ADDR)
                rd_word = DEV_ID_VAL;
            else if (tbl_addr == DEVREV_ADDR)
                rd_word = DEV_REV_VAL;
            else
                rd_word = '0;
        end
        else if (is_impl(tbl_addr))
            rd_word = sel_word(mem[tbl_idx], tbl_addr[0]);
        else
            rd_word = '0;
        vec_loc = (vec_alt_in ? AIVT_BASE : IVT_BASE) + {16'h0000, vec_num_in, 1'b0};
    end

    // --------------------------------------------------------------
    // Flash sequencer
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    cnt_q <= '0;
                    if (go_erase)
                        state_q <= ST_ERASE;
                    else if (go_prog)
                        state_q <= ST_PROG;
                end
                ST_ERASE, ST_PROG:
                begin
                    if (finish)
                        state_q <= ST_IDLE;
                    cnt_q <= cnt_q + CNT_W'(1);
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // CPU is held for the whole self-timed cycle, not just the array writes
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            stall_q <= 1'b0;
        else
            stall_q <= go_erase || go_prog || (!idle && !finish);
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            key_q <= KEY_LOCKED;
        else if (nvm_ctrl_wr_in)
            key_q <= KEY_LOCKED;
        else if (nvm_key_wr_in)
        begin
            if (nvm_key_in == KEY1)
                key_q <= KEY_HALF;
            else if (nvm_key_in == KEY2 && key_q == KEY_HALF)
                key_q <= KEY_OPEN;
            else
                key_q <= KEY_LOCKED;
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            ctrl_q <= '0;
        else
        begin
            ctrl_q[CTL_WR] <= go_erase || go_prog || (!idle && !finish);
            if (nvm_ctrl_wr_in)
            begin
                ctrl_q[CTL_WREN] <= nvm_ctrl_in[CTL_WREN];
                ctrl_q[CTL_ERASE] <= nvm_ctrl_in[CTL_ERASE];
            end
            // Error set beats a software clear in the same cycle
            ctrl_q[CTL_WRERR] <= prog_err ||
                (ctrl_q[CTL_WRERR] && !(nvm_ctrl_wr_in && !nvm_ctrl_in[CTL_WRERR]));
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            erased_q <= '0;
        else if (go_erase)
        begin
            for (int i = 0; i < WB_PER_EB; i++)
                erased_q[{latch_wb_q[WBN_W-1:EB_W-WB_W], 3'(i)}] <= 1'b1;
        end
        else if (go_prog)
            erased_q[latch_wb_q] <= 1'b0;
    end

    // --------------------------------------------------------------
    // Array and write latches
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk_in)
    begin
        if (state_q == ST_ERASE && cnt_q < CNT_W'(EB_INSTR))
            mem[{latch_wb_q[WBN_W-1:EB_W-WB_W], cnt_q[EB_W-1:0]}] <= ERASED_VAL;
        else if (state_q == ST_PROG && cnt_q < CNT_W'(WB_INSTR))
            mem[{latch_wb_q, cnt_q[WB_W-1:0]}] <= latch_q[cnt_q[WB_W-1:0]];
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            latch_wb_q <= '0;
            for (int i = 0; i < WB_INSTR; i++)
                latch_q[i] <= ERASED_VAL;
        end
        else if (wr_ok)
        begin
            latch_wb_q <= tbl_idx[IDX_W-1:WB_W];
            if (tbl_addr[0])
            begin
                // Only the implemented low byte of an upper word takes data
                if (!tbl_byte_in || !tbl_hi_byte_in)
                    latch_q[tbl_idx[WB_W-1:0]][INSTR_W-1:WORD_W] <= tbl_wdata_in[BYTE_W-1:0];
            end
            else if (!tbl_byte_in)
                latch_q[tbl_idx[WB_W-1:0]][WORD_W-1:0] <= tbl_wdata_in;
            else if (tbl_hi_byte_in)
                latch_q[tbl_idx[WB_W-1:0]][WORD_W-1:BYTE_W] <= tbl_wdata_in[BYTE_W-1:0];
            else
                latch_q[tbl_idx[WB_W-1:0]][BYTE_W-1:0] <= tbl_wdata_in[BYTE_W-1:0];
        end
    end

    // --------------------------------------------------------------
    // Table read
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rdata_q <= '0;
            ack_q <= 1'b0;
            refused_q <= 1'b0;
        end
        else
        begin
            ack_q <= tbl_take;
            refused_q <= wr_refused;
            if (tbl_take && table_read_op_in)
            begin
                if (!tbl_byte_in)
                    rdata_q <= rd_word;
                else if (tbl_hi_byte_in)
                    rdata_q <= {ZERO_BYTE, rd_word[WORD_W-1:BYTE_W]};
                else
                    rdata_q <= {ZERO_BYTE, rd_word[BYTE_W-1:0]};
            end
        end
    end

    // --------------------------------------------------------------
    // Fetch, vectors, configuration words
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            pc_q <= RESET_VEC;
        else if (jump_in && idle)
            pc_q <= {jump_addr_in[ADDR_W-1:1], 1'b0};
        else if (fetch_step_in && idle)
            pc_q <= pc_q + PC_STEP;
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            instr_q <= '0;
        else
            instr_q <= is_impl(pc_q) ? mem[idx_of(pc_q)] : '0;
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            vec_q <= '0;
            vec_valid_q <= 1'b0;
        end
        else
        begin
            vec_valid_q <= vec_req_in;
            if (vec_req_in)
                vec_q <= (vec_num_in < NUM_VECTORS) ? mem[idx_of(vec_loc)] : '0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            cfg1_q <= '1;
            cfg2_q <= '1;
        end
        else
        begin
            cfg1_q <= mem[CFG1_IDX][WORD_W-1:0];
            cfg2_q <= mem[CFG2_IDX][WORD_W-1:0];
        end
    end

    assign pc_out = pc_q;
    assign instr_out = instr_q;
    assign tbl_rdata_out = rdata_q;
    assign tbl_ack_out = ack_q;
    assign tbl_refused_out = refused_q;
    assign vec_addr_out = vec_q;
    assign vec_valid_out = vec_valid_q;
    assign nvm_ctrl_out = ctrl_q;
    assign stall_out = stall_q;
    assign cfg_word1_out = cfg1_q;
    assign cfg_word2_out = cfg2_q;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);

    sequence s_erase_start;
        go_erase;
    endsequence

    sequence s_stall_run;
        stall_q [*8] ##[A_ERASE_MIN:A_ERASE_MAX] !stall_q;
    endsequence

    a_pc_step_two: assert property (fetch_step_in && !jump_in && idle |=> pc_q == $past(pc_q) + PC_STEP)
        else $error("pc did not advance by two");
    a_pc_even_jump: assert property (jump_in && idle |=> !pc_q[0])
        else $error("jump target not even");
    a_phantom_zero: assert property (tbl_take && table_read_op_in && tbl_addr[0] && !tbl_cfg
        |=> rdata_q[WORD_W-1:BYTE_W] == ZERO_BYTE)
        else $error("upper word top byte not zero");
    a_cfg_refused: assert property (tbl_take && !table_read_op_in && tbl_cfg |=> refused_q && ack_q)
        else $error("config space write not refused");
    a_devid_read: assert property (tbl_take && table_read_op_in && !tbl_byte_in && tbl_addr == DEVID_ADDR
        |=> rdata_q == DEV_ID_VAL)
        else $error("device id read wrong");
    a_outside_zero: assert property (tbl_take && table_read_op_in && !tbl_cfg && !is_impl(tbl_addr)
        |=> rdata_q == '0)
        else $error("unimplemented read not zero");
    a_erase_stall: assert property (s_erase_start |=> s_stall_run)
        else $error("erase stall length wrong");
    a_prog_err_flag: assert property (prog_err |=> ctrl_q[CTL_WRERR] && !stall_q)
        else $error("write to unerased block not flagged");
    a_locked_start: assert property (nvm_ctrl_wr_in && key_q != KEY_OPEN && idle |=> idle && !stall_q)
        else $error("flash started without unlock");
    a_vec_range: assert property (vec_req_in && vec_num_in >= NUM_VECTORS |=> vec_valid_q && vec_q == '0)
        else $error("out of range vector not zero");

endmodule : pmm_program_memory

// ===== verification/pmm_cpu_model.sv
// CPU-side model: table accesses and flash control writes
`timescale 1ns/10ps
module pmm_cpu_model
    import pmm_pkg::*;
(
    input wire logic sys_clk_in,
    output logic tbl_req_out,
    output logic table_read_op_out,
    output logic table_write_op_out,
    output logic [7:0] table_page_select_out,
    output logic [WORD_W-1:0] offset_out,
    output logic byte_out,
    output logic hi_byte_out,
    output logic [WORD_W-1:0] wdata_out,
    output logic ctrl_wr_out,
    output logic [7:0] ctrl_out,
    output logic key_wr_out,
    output logic [7:0] key_out
);
    initial
    begin
        {tbl_req_out, table_read_op_out, table_write_op_out, table_page_select_out, offset_out, byte_out,
         hi_byte_out, wdata_out, ctrl_wr_out, ctrl_out, key_wr_out, key_out} = '0;
    end

    // --------------------------------------------------------------
    // Table bus
    // --------------------------------------------------------------
    // Slow mode drops the request for a cycle between accesses
    task automatic access(input logic w, input logic [ADDR_W-1:0] ea, input logic b, input logic h,
                          input logic [WORD_W-1:0] d, input logic slow);
        @(posedge sys_clk_in);
        tbl_req_out <= 1'b1;
        table_read_op_out <= !w;
        table_write_op_out <= w;
        {table_page_select_out, offset_out} <= ea;
        byte_out <= b;
        hi_byte_out <= h;
        wdata_out <= d;
        if (slow)
        begin
            @(posedge sys_clk_in);
            release_bus();
        end
    endtask : access

    // Released offset and data lines flip so stale values never look valid
    task automatic release_bus();
        tbl_req_out <= 1'b0;
        table_read_op_out <= 1'b0;
        table_write_op_out <= 1'b0;
        offset_out <= ~offset_out;
        wdata_out <= ~wdata_out;
    endtask : release_bus

    // --------------------------------------------------------------
    // Flash control
    // --------------------------------------------------------------
    // Key pair back to back, sent before a start only when keyed is set
    task automatic start_op(input logic [7:0] c, input logic keyed);
        if (keyed)
        begin
            @(posedge sys_clk_in);
            key_wr_out <= 1'b1;
            key_out <= KEY1;
            @(posedge sys_clk_in);
            key_out <= KEY2;
        end
        @(posedge sys_clk_in);
        key_wr_out <= 1'b0;
        key_out <= ~key_out;
        ctrl_wr_out <= 1'b1;
        ctrl_out <= c;
        @(posedge sys_clk_in);
        ctrl_wr_out <= 1'b0;
        ctrl_out <= ~c;
    endtask : start_op
endmodule : pmm_cpu_model

// ===== verification/program_memory_map_tb_top.sv
// Self-checking bench for the program memory block
`timescale 1ns/10ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_total++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module program_memory_map_tb_top
    import pmm_pkg::*;
;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic fetch_step = 1'b0;
    logic jump = 1'b0;
    logic [ADDR_W-1:0] jump_addr = '0;
    logic vec_req = 1'b0;
    logic vec_alt = 1'b0;
    logic [6:0] vec_num = '0;
    logic req, rd_op, wr_op, byte_sel, hi_sel, ctrl_wr, key_wr;
    logic [7:0] page, ctrl, key, ctrl_rd;
    logic [WORD_W-1:0] offset, wdata, rdata, cfg1, cfg2;
    logic [ADDR_W-1:0] pc_out;
    logic [INSTR_W-1:0] instr_out, vec_addr;
    logic ack, refused, vec_valid, stall_out;
    int err_total = 0;
    int checks = 0;
    logic slow = 1'b0;
    logic [17:0] sb[$];
    logic [17:0] e;
    logic [31:0] seed = 32'h90ac;
    logic [INSTR_W-1:0] img [8];

    always #20 sys_clk = ~sys_clk;

    pmm_program_memory dut_u (.sys_clk_in(sys_clk), .resetn_in(resetn), .fetch_step_in(fetch_step),
        .jump_in(jump), .jump_addr_in(jump_addr), .pc_out(pc_out), .instr_out(instr_out), .tbl_req_in(req),
        .table_read_op_in(rd_op), .table_write_op_in(wr_op), .table_page_select_in(page),
        .tbl_offset_in(offset), .tbl_byte_in(byte_sel), .tbl_hi_byte_in(hi_sel), .tbl_wdata_in(wdata),
        .tbl_rdata_out(rdata), .tbl_ack_out(ack), .tbl_refused_out(refused), .vec_req_in(vec_req),
        .vec_alt_in(vec_alt), .vec_num_in(vec_num), .vec_addr_out(vec_addr), .vec_valid_out(vec_valid),
        .nvm_ctrl_wr_in(ctrl_wr), .nvm_ctrl_in(ctrl), .nvm_key_wr_in(key_wr), .nvm_key_in(key),
        .nvm_ctrl_out(ctrl_rd), .stall_out(stall_out), .cfg_word1_out(cfg1), .cfg_word2_out(cfg2));

    pmm_cpu_model cpu_u (.sys_clk_in(sys_clk), .tbl_req_out(req), .table_read_op_out(rd_op),
        .table_write_op_out(wr_op), .table_page_select_out(page), .offset_out(offset), .byte_out(byte_sel),
        .hi_byte_out(hi_sel), .wdata_out(wdata), .ctrl_wr_out(ctrl_wr), .ctrl_out(ctrl), .key_wr_out(key_wr),
        .key_out(key));

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic rd(input logic [ADDR_W-1:0] ea, input logic b, input logic h, input logic [WORD_W-1:0] x);
        sb.push_back({1'b1, 1'b0, x});
        cpu_u.access(1'b0, ea, b, h, 16'h0000, slow);
    endtask : rd

    task automatic wr(input logic [ADDR_W-1:0] ea, input logic b, input logic h, input logic [WORD_W-1:0] d,
                      input logic r);
        sb.push_back({1'b0, r, 16'h0000});
        cpu_u.access(1'b1, ea, b, h, d, slow);
    endtask : wr

    task automatic idle();
        @(posedge sys_clk);
        cpu_u.release_bus();
    endtask : idle

    // Counts stalled edges over a window longer than any operation
    task automatic run_op(input logic [7:0] c, input logic keyed, input int exp_cyc);
        int n;
        n = 0;
        cpu_u.start_op(c, keyed);
        repeat (100)
        begin
            @(posedge sys_clk);
            n += int'(stall_out !== 1'b0);
            `CHK(ctrl_rd[CTL_WR], stall_out)
        end
        `CHK(n, exp_cyc)
    endtask : run_op

    task automatic vec(input logic alt, input logic [6:0] num, input logic [INSTR_W-1:0] x);
        vec_req <= 1'b1;
        vec_alt <= alt;
        vec_num <= num;
        @(posedge sys_clk);
        vec_req <= 1'b0;
        @(posedge sys_clk);
        `CHK(vec_valid, 1'b1)
        `CHK(vec_addr, x)
    endtask : vec

    task automatic note(input string name);
        $display("test %s done", name);
    endtask : note

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    // --------------------------------------------------------------
    // Scoreboard
    // --------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        if (ack === 1'b1)
        begin
            `CHK(sb.size() > 0, 1'b1)
            e = sb.pop_front();
            if (e[17])
                `CHK(rdata, e[15:0])
            `CHK(refused, e[16])
        end
    end

    // Watchdog sized well past the expected run of under a thousand cycles
    initial
    begin
        #(CLK_PERIOD_NS * 20000);
        err_total++;
        conclude();
    end

    // --------------------------------------------------------------
    // Tests
    // --------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge sys_clk);
        `CHK(pc_out, 24'h000000)
        `CHK(ctrl_rd, 8'h00)
        `CHK(cfg1, 16'hffff)
        `CHK(cfg2, 16'hffff)
        resetn <= 1'b1;
        note("reset");
        rd(DEVID_ADDR, 1'b0, 1'b0, DEV_ID_VAL);
        rd(DEVREV_ADDR, 1'b0, 1'b0, DEV_REV_VAL);
        rd(24'hff0004, 1'b0, 1'b0, 16'h0000);
        rd(24'h000801, 1'b0, 1'b0, 16'h0000);
        wr(24'hff0000, 1'b0, 1'b0, 16'h1234, 1'b1);
        wr(24'h800001, 1'b1, 1'b0, 16'h0012, 1'b1);
        wr(24'h7ffffe, 1'b0, 1'b0, 16'h1234, 1'b0);
        wr(24'h000000, 1'b0, 1'b0, 16'h0000, 1'b0);
        idle();
        note("map");
        run_op(8'h03, 1'b0, 0);
        run_op(8'h07, 1'b1, ERASE_CYC);
        slow = 1'b1;
        rd(24'h000000, 1'b0, 1'b0, 16'hffff);
        rd(24'h000001, 1'b0, 1'b0, 16'h00ff);
        rd(24'h000001, 1'b1, 1'b1, 16'h0000);
        slow = 1'b0;
        note("erase");
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            img[i] = seed[23:0];
            wr(24'(2 * i), 1'b0, 1'b0, seed[15:0], 1'b0);
            wr(24'(2 * i + 1), 1'b0, 1'b0, seed[31:16], 1'b0);
        end
        wr(24'h000003, 1'b1, 1'b1, 16'h00ff, 1'b0);
        wr(24'h000004, 1'b1, 1'b0, 16'h005a, 1'b0);
        img[2][7:0] = 8'h5a;
        idle();
        run_op(8'h03, 1'b1, WRITE_CYC);
        for (int i = 0; i < 8; i++)
        begin
            rd(24'(2 * i), 1'b0, 1'b0, img[i][15:0]);
            rd(24'(2 * i + 1), 1'b0, 1'b0, {8'h00, img[i][23:16]});
            rd(24'(2 * i), 1'b1, 1'b1, {8'h00, img[i][15:8]});
            rd(24'(2 * i + 1), 1'b1, 1'b1, 16'h0000);
        end
        idle();
        note("program");
        run_op(8'h03, 1'b1, 0);
        `CHK(ctrl_rd[CTL_WRERR], 1'b1)
        cpu_u.start_op(8'h00, 1'b0);
        @(posedge sys_clk);
        `CHK(ctrl_rd, 8'h00)
        note("error");
        jump <= 1'b1;
        jump_addr <= 24'h000005;
        @(posedge sys_clk);
        jump <= 1'b0;
        repeat (3) @(posedge sys_clk);
        `CHK(pc_out, 24'h000004)
        `CHK(instr_out, img[2])
        fetch_step <= 1'b1;
        repeat (3) @(posedge sys_clk);
        fetch_step <= 1'b0;
        repeat (3) @(posedge sys_clk);
        `CHK(pc_out, 24'h000004 + 3 * PC_STEP)
        `CHK(instr_out, img[5])
        jump <= 1'b1;
        jump_addr <= 24'h000800;
        @(posedge sys_clk);
        jump <= 1'b0;
        repeat (3) @(posedge sys_clk);
        `CHK(instr_out, 24'h000000)
        note("fetch");
        wr(24'h000106, 1'b0, 1'b0, 16'h0000, 1'b0);
        idle();
        run_op(8'h07, 1'b1, ERASE_CYC);
        wr(24'h0007fc, 1'b0, 1'b0, 16'h2468, 1'b0);
        wr(24'h0007fe, 1'b0, 1'b0, 16'h1357, 1'b0);
        idle();
        run_op(8'h07, 1'b1, ERASE_CYC);
        run_op(8'h03, 1'b1, WRITE_CYC);
        `CHK(cfg1, 16'h2468)
        `CHK(cfg2, 16'h1357)
        vec(1'b1, 7'd0, ERASED_VAL);
        vec(1'b0, 7'd0, img[3]);
        vec(1'b0, NUM_VECTORS, 24'h000000);
        vec(1'b1, NUM_VECTORS, 24'h000000);
        note("vector");
        `CHK(sb.size(), 0)
        conclude();
    end
endmodule : program_memory_map_tb_top
